// File: rtl/mtbv_pkg.sv
package mtbv_pkg;
    // Division count and bus widths
    localparam int NUM_DIV = 3;
    localparam int AW = 4;
    // Register byte offsets
    localparam logic [AW-1:0] OFS_MODE = 4'h0;
    localparam logic [AW-1:0] OFS_STAT = 4'h4;
    localparam logic [AW-1:0] OFS_IRQS = 4'h8;
    localparam logic [AW-1:0] OFS_IRQM = 4'hC;
    // Event bit positions in status and mask
    localparam int EV_ACT = 0;
    localparam int EV_MAINT = 1;
    localparam int EV_LANE = 2;
    localparam int NUM_EV = 3;
    // Values after reset
    localparam logic [NUM_EV-1:0] RST_IRQM = 3'h0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/mtbv_voter.sv
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Each division's trip/bypass switch feeds only that division's voting logic.
// RQ2: Function modules report out-of-service position and partial trips continuously.
// RQ3: In operate with a healthy module, trip/bypass switch is ignored.
// RQ4: Out of service plus trip forces every partial trip to tripped.
// RQ5: Out of service plus bypass forces every partial trip to not tripped.
// RQ6: Two-out-of-three functions actuate when two divisions are tripped.
// RQ7: One-out-of-two functions actuate on one tripped input.
// RQ8: Manual actuation cannot be bypassed and equals automatic priority.
// RQ9: Manual pushbuttons go straight to priority logic, not through voting.
// RQ10: Safety actuation outranks plant control system nonsafety signals.
// RQ11: Out-of-service module in either switch position marks channels inoperable.
// RQ12: Voting lanes check each other and flag a disagreeing lane.
// RQ13: Interface stage actuates when two of three voting lanes demand.
// RQ14: A failed voting lane is read as a trip demand.
// RQ15: With nonsafety enable off, nonsafety controls have no effect.
// RQ16: Actuation stays latched until deliberate operator reset.
// RQ17: Switch forcing is re-evaluated every cycle.
module mtbv_voter
    import mtbv_pkg::*;
#(
    parameter int NF = 4
) (
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // Sync reset, active low
    input wire logic [AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [NUM_DIV-1:0][NF-1:0] partial_trip, // Per division
    input wire logic [NUM_DIV-1:0] out_of_service_switch, // 1 = out of service
    input wire logic [NUM_DIV-1:0] trip_bypass_sw, // From input module, 1 = trip
    input wire logic [NUM_DIV-1:0] module_healthy, // Function module healthy
    input wire logic [NUM_DIV-1:0] lane_fail, // Voting lane self-test failed
    input wire logic [NF-1:0] manual_act, // Manual pushbuttons
    input wire logic enable_nonsafety, // Nonsafety enable switch
    input wire logic [NF-1:0] nonsafety_ctl, // Plant control system commands
    input wire logic operator_reset, // Deliberate reset pushbutton
    output logic [NF-1:0] actuate, // To actuated equipment
    output logic [NUM_DIV-1:0] chan_inop, // Channels inoperable
    output logic irq // Level interrupt
);
    logic [NUM_DIV-1:0][NF-1:0] eff_pt, next_eff_pt;
    logic [NUM_DIV-1:0][NF-1:0] lane_q, next_lane_q;
    logic [NF-1:0] lat, next_lat;
    logic [NF-1:0] next_actuate;
    logic [NUM_DIV-1:0] next_chan_inop;
    logic [NF-1:0] mode, next_mode;
    logic [NUM_EV-1:0] irq_stat, next_irq_stat;
    logic [NUM_EV-1:0] irq_mask, next_irq_mask;
    logic next_irq;
    logic [NF-1:0] vote;
    logic [NUM_EV-1:0] ev;
    logic lane_err;

    // Switch forcing per division, redone every cycle
    always_comb begin
        for (int d = 0; d < NUM_DIV; d++) begin
            // RQ4 RQ5 RQ1 forcing from own switch
            if (out_of_service_switch[d]) begin
                next_eff_pt[d] = trip_bypass_sw[d] ? {NF{1'b1}} : {NF{1'b0}};
            end else if (!module_healthy[d]) begin
                // Failed module drives its trips safe-side
                next_eff_pt[d] = {NF{1'b1}};
            end else begin
                // RQ3 switch ignored in operate
                next_eff_pt[d] = partial_trip[d];
            end
            // RQ11 channels inoperable
            next_chan_inop[d] = out_of_service_switch[d];
        end
    end

    // Coincidence vote, copied into three lanes
    always_comb begin
        for (int f = 0; f < NF; f++) begin
            // RQ7 one out of two on divisions 0 and 1
            if (mode[f]) begin
                vote[f] = eff_pt[0][f] | eff_pt[1][f];
            end else begin
                // RQ6 two out of three
                vote[f] = (eff_pt[0][f] & eff_pt[1][f]) | (eff_pt[0][f] & eff_pt[2][f])
                    | (eff_pt[1][f] & eff_pt[2][f]);
            end
        end
        for (int l = 0; l < NUM_DIV; l++) begin
            // RQ14 failed lane reads as trip
            next_lane_q[l] = lane_fail[l] ? {NF{1'b1}} : vote;
        end
    end

    // Interface stage, latch and priority
    always_comb begin
        lane_err = 1'b0;
        for (int f = 0; f < NF; f++) begin
            // RQ13 two of three lanes
            next_lat[f] = (lane_q[0][f] & lane_q[1][f]) | (lane_q[0][f] & lane_q[2][f])
                | (lane_q[1][f] & lane_q[2][f]);
            // RQ16 hold until operator reset; new demand wins
            next_lat[f] = next_lat[f] | manual_act[f] | (lat[f] & ~operator_reset);
            // RQ8 RQ9 RQ10 RQ15 safety first, nonsafety gated
            next_actuate[f] = next_lat[f] | manual_act[f] | (enable_nonsafety & nonsafety_ctl[f]);
        end
        // RQ12 lane cross-check
        for (int l = 1; l < NUM_DIV; l++) begin
            lane_err = lane_err | (lane_q[l] != lane_q[0]);
        end
    end

    // Pipeline and output registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eff_pt <= '0;
            lane_q <= '0;
            lat <= '0;
            actuate <= '0;
            chan_inop <= '0;
        end else begin
            // RQ17 re-evaluated every cycle
            eff_pt <= next_eff_pt;
            lane_q <= next_lane_q;
            lat <= next_lat;
            actuate <= next_actuate;
            chan_inop <= next_chan_inop;
        end
    end

    // Bus slave state
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [AW-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_wr;

    // Events: new latch, maintenance forcing, lane fault
    assign ev[EV_ACT] = |(next_lat & ~lat);
    assign ev[EV_MAINT] = |out_of_service_switch;
    assign ev[EV_LANE] = lane_err | (|lane_fail);

    // Bus decode, register writes and reads
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_mode = mode;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_wr = aw_held && w_held && !s_axi_bvalid;
        if (do_wr) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            case (aw_addr)
                OFS_MODE: begin
                    if (w_strb[0]) begin
                        next_mode = w_data[NF-1:0];
                    end
                end
                OFS_IRQS: begin
                    if (w_strb[0]) begin
                        next_irq_stat = irq_stat & ~w_data[NUM_EV-1:0];
                    end
                end
                OFS_IRQM: begin
                    if (w_strb[0]) begin
                        next_irq_mask = w_data[NUM_EV-1:0];
                    end
                end
                OFS_STAT: next_bresp = RESP_OKAY; // Read only, write ignored
                default: next_bresp = RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Set wins over a same-cycle clear
        next_irq_stat = next_irq_stat | ev;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0;
            case (s_axi_araddr)
                OFS_MODE: next_rdata[NF-1:0] = mode;
                OFS_STAT: next_rdata[NF+NUM_DIV-1:0] = {chan_inop, lat};
                OFS_IRQS: next_rdata[NUM_EV-1:0] = irq_stat;
                OFS_IRQM: next_rdata[NUM_EV-1:0] = irq_mask;
                default: next_rresp = RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // Bus registers; ready flags drop while a word is parked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
            mode <= '0;
            irq_mask <= RST_IRQM;
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
            s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            mode <= next_mode;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            irq <= next_irq;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_maint_trip;
        out_of_service_switch[0] && trip_bypass_sw[0];
    endsequence
    sequence s_maint_byp;
        out_of_service_switch[0] && !trip_bypass_sw[0];
    endsequence

    property p_force_trip;
        s_maint_trip |=> eff_pt[0] == {NF{1'b1}};
    endproperty
    a_force_trip: assert property (p_force_trip) else $error("maintenance trip not forced"); // RQ4

    property p_force_byp;
        s_maint_byp |=> eff_pt[0] == {NF{1'b0}} ##0 chan_inop[0];
    endproperty
    a_force_byp: assert property (p_force_byp) else $error("maintenance bypass not forced"); // RQ5

    property p_operate;
        !out_of_service_switch[1] && module_healthy[1] |=> eff_pt[1] == $past(partial_trip[1]);
    endproperty
    a_operate: assert property (p_operate) else $error("switch not ignored in operate"); // RQ3

    property p_one_of_two;
        mode[0] && eff_pt[0][0] && !lane_fail[0] |=> lane_q[0][0];
    endproperty
    a_one_of_two: assert property (p_one_of_two) else $error("one of two vote missed"); // RQ7

    property p_two_of_three;
        !mode[0] && $countones({eff_pt[2][0], eff_pt[1][0], eff_pt[0][0]}) < 2
            && lane_fail == 3'h0 |=> !lane_q[1][0];
    endproperty
    a_two_of_three: assert property (p_two_of_three) else $error("vote without coincidence"); // RQ6

    property p_maint_act;
        mode[0] ##0 s_maint_trip ##1 mode[0] ##0 s_maint_trip ##1 lane_fail == 3'h0
            |=> lat[0] ##0 actuate[0];
    endproperty
    a_maint_act: assert property (p_maint_act) else $error("maintenance trip did not actuate"); // RQ7

    property p_lane_fail;
        lane_fail[2] |=> lane_q[2] == {NF{1'b1}};
    endproperty
    a_lane_fail: assert property (p_lane_fail) else $error("failed lane not a trip"); // RQ14

    property p_majority;
        lane_q[0][1] && lane_q[2][1] |=> lat[1];
    endproperty
    a_majority: assert property (p_majority) else $error("two lanes did not latch"); // RQ13

    property p_manual;
        manual_act[0] |=> actuate[0];
    endproperty
    a_manual: assert property (p_manual) else $error("manual actuation lost"); // RQ8

    property p_ns_off;
        !enable_nonsafety && !next_lat[1] && !manual_act[1] |=> !actuate[1];
    endproperty
    a_ns_off: assert property (p_ns_off) else $error("nonsafety acted while disabled"); // RQ15

    property p_hold;
        lat[0] && !operator_reset |=> lat[0] [*1];
    endproperty
    a_hold: assert property (p_hold) else $error("latch released without reset"); // RQ16
endmodule

// File: test/mtbv_sfm_model.sv
`timescale 1ns/1ps
// Function modules of all divisions plus the switch input module
module mtbv_func_model
    import mtbv_pkg::*;
#(parameter int NF = 4) (
    input wire logic aclk, // Clock
    input wire logic [NUM_DIV-1:0][NF-1:0] want_trip, // Trips to report
    input wire logic [NUM_DIV-1:0] want_svc, // Switch positions to report
    input wire logic [NUM_DIV-1:0] want_tb, // Trip/bypass positions
    input wire logic [NUM_DIV-1:0] want_ok, // Module health
    output logic [NUM_DIV-1:0][NF-1:0] partial_trip = '0, // Partial trips
    output logic [NUM_DIV-1:0] out_of_service_switch = '0, // Switch report
    output logic [NUM_DIV-1:0] trip_bypass_sw = '0, // Logic-level switch
    output logic [NUM_DIV-1:0] module_healthy = '1 // Health report
);
    // continuous status report
    // Sent every cycle, so a stale switch report never lingers
    always @(posedge aclk) begin
        partial_trip <= want_trip;
        out_of_service_switch <= want_svc;
        trip_bypass_sw <= want_tb;
        module_healthy <= want_ok;
    end
endmodule

// File: test/maintenance_trip_bypass_voting_bench.sv
`timescale 1ns/1ps
module maintenance_trip_bypass_voting_bench
    import mtbv_pkg::*;
;
    // Stimulus and observed outputs
    localparam int NF = 4;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NUM_DIV-1:0][NF-1:0] want_trip = '0, partial_trip;
    logic [NUM_DIV-1:0] want_svc = '0, want_tb = '0, want_ok = '1, lane_fail = '0;
    logic [NUM_DIV-1:0] out_of_service_switch, trip_bypass_sw, module_healthy, chan_inop;
    logic [NF-1:0] manual_act = '0, nonsafety_ctl = '0, actuate;
    logic enable_nonsafety = 1'h0, operator_reset = 1'h0;
    int fails = 0, num_checks = 0;
    // Voter fed by the function-module model
    mtbv_voter #(.NF(NF)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .partial_trip,
        .out_of_service_switch, .trip_bypass_sw, .module_healthy, .lane_fail, .manual_act,
        .enable_nonsafety, .nonsafety_ctl, .operator_reset, .actuate, .chan_inop, .irq);
    mtbv_func_model #(.NF(NF)) func_u (.aclk, .want_trip, .want_svc, .want_tb, .want_ok,
        .partial_trip, .out_of_service_switch, .trip_bypass_sw, .module_healthy);
    // 100 MHz clock
    always #5 aclk = ~aclk;
    // Hang guard; the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        wrap_up();
    end
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic act(input logic [NF-1:0] e);
        chk("actuate", 32'(e), 32'(actuate));
    endtask
    // Ends on a falling edge so registered outputs have settled
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    // One bus transfer; readies seen mid-cycle are acted on at the next edge
    task automatic bus(input logic we, input logic [AW-1:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [1:0] er);
        logic done, ta, tw;
        logic [31:0] q;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_bready <= we;
        s_axi_arvalid <= !we;
        s_axi_rready <= !we;
        done = 1'h0;
        while (!done) begin
            @(negedge aclk);
            done = we ? s_axi_bvalid : s_axi_rvalid;
            ta = we ? s_axi_awready : s_axi_arready;
            tw = s_axi_wready;
            q = s_axi_rdata;
            r = we ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (ta) s_axi_arvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        if (!we) chk("rdata", e, q);
        chk("resp", 32'(er), 32'(r));
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0, e, RESP_OKAY);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        bus(1'h1, a, d, 32'h0, er);
    endtask
    // Commands to the model, then settle through the voting pipeline
    task automatic set_mods(input logic [2:0] svc, input logic [2:0] tb, input logic [2:0] ok,
                            input logic [11:0] tr);
        @(posedge aclk);
        want_svc <= svc;
        want_tb <= tb;
        want_ok <= ok;
        want_trip <= tr;
        wt(5);
    endtask
    // Back to normal: switches home, latches reset, events cleared
    task automatic idle();
        @(posedge aclk);
        lane_fail <= '0;
        manual_act <= '0;
        nonsafety_ctl <= '0;
        enable_nonsafety <= 1'h0;
        operator_reset <= 1'h1;
        set_mods(3'h0, 3'h0, 3'h7, 12'h0);
        @(posedge aclk);
        operator_reset <= 1'h0;
        wr(OFS_IRQS, 32'h7, RESP_OKAY);
    endtask
    // Reset values, read-only status, an unmapped place
    task automatic s_regs();
        rd(OFS_IRQM, 32'(RST_IRQM));
        rd(OFS_MODE, 32'h0);
        wr(OFS_STAT, 32'h7F, RESP_OKAY);
        rd(OFS_STAT, 32'h0);
        wr(4'h6, 32'h1, RESP_SLVERR);
        bus(1'h0, 4'h6, 32'h0, 32'h0, RESP_SLVERR);
    endtask
    // Maintenance trip, one live trip, a stray switch in operate
    task automatic s_trip();
        set_mods(3'h1, 3'h5, 3'h7, {4'h0, 4'h1, 4'h0});
        act(4'h1);
        chk("chan_inop", 32'h1, 32'(chan_inop));
        rd(OFS_STAT, 32'h11);
    endtask
    // Bypass hides a tripped module until the switch goes home
    task automatic s_byp();
        set_mods(3'h1, 3'h0, 3'h7, {4'h0, 4'h2, 4'hF});
        act(4'h0);
        chk("chan_inop", 32'h1, 32'(chan_inop));
        set_mods(3'h0, 3'h0, 3'h7, {4'h0, 4'h2, 4'hF});
        act(4'h2);
        rd(OFS_IRQS, 32'h3);
    endtask
    // One-out-of-two: a maintenance trip alone actuates
    task automatic s_one();
        wr(OFS_MODE, 32'hF, RESP_OKAY);
        set_mods(3'h1, 3'h1, 3'h7, 12'h0);
        act(4'hF);
        wr(OFS_MODE, 32'h0, RESP_OKAY);
    endtask
    // Unhealthy module, then faulty voting lanes
    task automatic s_lane();
        set_mods(3'h0, 3'h7, 3'h6, 12'h800);
        act(4'h8);
        idle();
        @(posedge aclk);
        lane_fail <= 3'h4;
        wt(4);
        act(4'h0);
        rd(OFS_IRQS, 32'h4);
        @(posedge aclk);
        lane_fail <= 3'h5;
        wt(4);
        act(4'hF);
    endtask
    // Nonsafety gate, manual priority, latch and deliberate reset
    task automatic s_man();
        @(posedge aclk);
        nonsafety_ctl <= 4'hF;
        wt(2);
        act(4'h0);
        @(posedge aclk);
        enable_nonsafety <= 1'h1;
        nonsafety_ctl <= 4'h0;
        manual_act <= 4'h4;
        operator_reset <= 1'h1;
        wt(3);
        act(4'h4);
        @(posedge aclk);
        manual_act <= 4'h0;
        operator_reset <= 1'h0;
        wt(3);
        act(4'h4);
        @(posedge aclk);
        operator_reset <= 1'h1;
        wt(2);
        act(4'h0);
    endtask
    // Masked event, unmasked level, clear by writing one
    task automatic s_irq();
        @(posedge aclk);
        manual_act <= 4'h1;
        wt(4);
        chk("irq", 32'h0, 32'(irq));
        wr(OFS_IRQM, 32'h1, RESP_OKAY);
        wt(2);
        chk("irq", 32'h1, 32'(irq));
        wr(OFS_IRQS, 32'h1, RESP_OKAY);
        wt(2);
        chk("irq", 32'h0, 32'(irq));
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        s_regs();
        s_trip();
        idle();
        s_byp();
        idle();
        s_one();
        idle();
        s_lane();
        idle();
        s_man();
        idle();
        s_irq();
        wrap_up();
    end
endmodule
